// file: verilog/pfm_port_mux.sv
// Port 1 / port 2 pin function multiplexer with its select registers.
// Assumes a byte register bus on clk; pad inputs are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module pfm_port_mux (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [5:0] pwm_out,
    input wire logic [5:0] port1_general_io,
    input wire logic [5:0] port1_general_io_oe,
    output logic [5:0] p1_pad_out,
    output logic [5:0] p1_pad_oe,
    input wire logic [5:0] port2_input_lines,
    output logic [5:0] p2_pad_out,
    output logic [5:0] p2_pad_oe,
    output logic [5:0] p2_pullup_off_bits,
    output logic p2_upper_pad_speed,
    output logic [5:0] fast_digital_input,
    input wire logic i2c_scl_pull_low,
    input wire logic i2c_sda_pull_low,
    output logic i2c_scl_in,
    output logic i2c_sda_in
);
    logic [7:0] port1_function_select_q;
    logic [7:0] port2_function_select_q;
    logic [7:0] port2_pullup_disable_q;
    logic [7:0] index_q;
    logic [5:0] p2_sync;
    logic p2_upper_pair_route;
    logic hit_p1;
    logic hit_idx;
    logic hit_data;
    logic idx_pullup;
    logic idx_select;

    // Address decode; indirect registers only through the data window
    assign hit_p1 = (reg_addr == pfm_pkg::PORT1_FUNCTION_SELECT_ADDR);
    assign hit_idx = (reg_addr == pfm_pkg::INDIRECT_INDEX_ADDR);
    assign hit_data = (reg_addr == pfm_pkg::INDIRECT_DATA_ADDR);
    assign idx_pullup = (index_q == pfm_pkg::PORT2_PULLUP_DISABLE_IDX);
    assign idx_select = (index_q == pfm_pkg::PORT2_FUNCTION_SELECT_IDX);
    assign p2_upper_pair_route = port2_function_select_q[pfm_pkg::P2_UPPER_ROUTE_BIT];

    // Port 1 select register, reserved bits held at zero
    always_ff @(posedge clk) begin
        if (rst) begin
            port1_function_select_q <= pfm_pkg::PORT1_FUNCTION_SELECT_RESET;
        end else if (reg_wr && hit_p1) begin
            port1_function_select_q <= reg_wdata & pfm_pkg::PORT1_SELECT_MASK;
        end
    end

    // Indirect index register
    always_ff @(posedge clk) begin
        if (rst) begin
            index_q <= pfm_pkg::INDIRECT_INDEX_RESET;
        end else if (reg_wr && hit_idx) begin
            index_q <= reg_wdata;
        end
    end

    // Port 2 select, only the route bit is writable
    always_ff @(posedge clk) begin
        if (rst) begin
            port2_function_select_q <= pfm_pkg::PORT2_FUNCTION_SELECT_RESET;
        end else if (reg_wr && hit_data && idx_select) begin
            port2_function_select_q <= reg_wdata & pfm_pkg::PORT2_SELECT_MASK;
        end
    end

    // Port 2 pull-up disable bits
    always_ff @(posedge clk) begin
        if (rst) begin
            port2_pullup_disable_q <= pfm_pkg::PORT2_PULLUP_DISABLE_RESET;
        end else if (reg_wr && hit_data && idx_pullup) begin
            port2_pullup_disable_q <= reg_wdata & pfm_pkg::PORT2_PULLUP_MASK;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= pfm_pkg::UNMAPPED_READ_VALUE;
        end else if (reg_rd) begin
            if (hit_p1) begin
                reg_rdata <= port1_function_select_q;
            end else if (hit_idx) begin
                reg_rdata <= index_q;
            end else if (hit_data && idx_select) begin
                reg_rdata <= port2_function_select_q;
            end else if (hit_data && idx_pullup) begin
                reg_rdata <= port2_pullup_disable_q;
            end else begin
                reg_rdata <= pfm_pkg::UNMAPPED_READ_VALUE;
            end
        end
    end

    // Pad input synchroniser
    pfm_input_sync #(
        .WIDTH(pfm_pkg::P2_PIN_COUNT)
    ) u_p2_sync (
        .clk(clk),
        .rst(rst),
        .async_in(port2_input_lines),
        .sync_out(p2_sync)
    );

    // Port 1 pad mux, registered so pins never see decode glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            p1_pad_out <= 6'h00;
            p1_pad_oe <= 6'h00;
        end else begin
            for (int i = 0; i < pfm_pkg::P1_PIN_COUNT; i++) begin
                p1_pad_out[i] <= port1_function_select_q[i] ? pwm_out[i] : port1_general_io[i];
                p1_pad_oe[i] <= port1_function_select_q[i] | port1_general_io_oe[i];
            end
        end
    end

    // Port 2 routing, open-drain drive of the two-wire pair
    always_ff @(posedge clk) begin
        if (rst) begin
            p2_pad_out <= 6'h00;
            p2_pad_oe <= 6'h00;
            p2_pullup_off_bits <= pfm_pkg::PORT2_PULLUP_DISABLE_RESET[5:0];
            p2_upper_pad_speed <= pfm_pkg::PAD_SPEED_NORMAL;
            fast_digital_input <= 6'h3f;
            i2c_scl_in <= 1'b1;
            i2c_sda_in <= 1'b1;
        end else begin
            p2_pad_out <= 6'h00;
            p2_pad_oe[3:0] <= 4'h0;
            p2_pad_oe[pfm_pkg::P2_SCL_PIN] <= ~p2_upper_pair_route & i2c_scl_pull_low;
            p2_pad_oe[pfm_pkg::P2_SDA_PIN] <= ~p2_upper_pair_route & i2c_sda_pull_low;
            p2_pullup_off_bits <= port2_pullup_disable_q[5:0];
            p2_upper_pad_speed <= p2_upper_pair_route ? pfm_pkg::PAD_SPEED_NORMAL
                                                      : pfm_pkg::PAD_SPEED_FAST;
            fast_digital_input[3:0] <= p2_sync[3:0];
            fast_digital_input[5:4] <= p2_upper_pair_route ? p2_sync[5:4] : 2'b11;
            i2c_scl_in <= p2_upper_pair_route ? 1'b1 : p2_sync[pfm_pkg::P2_SCL_PIN];
            i2c_sda_in <= p2_upper_pair_route ? 1'b1 : p2_sync[pfm_pkg::P2_SDA_PIN];
        end
    end

    // Checks
    property p_p1_route;
        @(posedge clk) disable iff (rst)
        ##1 1 |-> p1_pad_out == (($past(port1_function_select_q[5:0]) & $past(pwm_out))
                                | (~$past(port1_function_select_q[5:0]) & $past(port1_general_io)));
    endproperty
    a_p1_route: assert property (p_p1_route) else $error("port 1 pin route wrong");

    property p_p1_reset;
        @(posedge clk) $fell(rst) |-> port1_function_select_q == 8'h3f;
    endproperty
    a_p1_reset: assert property (p_p1_reset) else $error("port 1 select reset wrong");

    property p_p2_i2c;
        @(posedge clk) disable iff (rst)
        !p2_upper_pair_route ##1 !$past(rst) |-> fast_digital_input[5:4] == 2'b11
            && p2_pad_oe[5] == $past(i2c_scl_pull_low);
    endproperty
    a_p2_i2c: assert property (p_p2_i2c) else $error("upper pair not on two-wire bus");

    property p_p2_reserved;
        @(posedge clk) disable iff (rst)
        (port2_function_select_q & ~pfm_pkg::PORT2_SELECT_MASK) == 8'h00;
    endproperty
    a_p2_reserved: assert property (p_p2_reserved) else $error("port 2 reserved bit set");

    property p_pullup;
        @(posedge clk) disable iff (rst)
        reg_wr && hit_data && idx_pullup ##2 1 |-> p2_pullup_off_bits == $past(reg_wdata[5:0], 2);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up bits not applied");

    property p_no_direct;
        @(posedge clk) disable iff (rst)
        reg_wr && !hit_data |=> $stable(port2_function_select_q) && $stable(port2_pullup_disable_q);
    endproperty
    a_no_direct: assert property (p_no_direct) else $error("indirect register written directly");

    property p_sel_index;
        @(posedge clk) disable iff (rst)
        reg_wr && hit_data && index_q == 8'h13 |=> port2_function_select_q == ($past(reg_wdata) & 8'h10);
    endproperty
    a_sel_index: assert property (p_sel_index) else $error("port 2 select index wrong");

    property p_speed;
        @(posedge clk) disable iff (rst)
        !p2_upper_pair_route ##1 !$past(rst) |-> p2_upper_pad_speed == pfm_pkg::PAD_SPEED_FAST;
    endproperty
    a_speed: assert property (p_speed) else $error("pad speed not fast on two-wire route");

    property p_next_cycle;
        @(posedge clk) disable iff (rst)
        reg_wr && hit_p1 ##1 !rst ##1 !rst |-> p1_pad_oe[0] == ($past(reg_wdata[0], 2)
                                                | $past(port1_general_io_oe[0]));
    endproperty
    a_next_cycle: assert property (p_next_cycle) else $error("route change late");
endmodule
`default_nettype wire

// file: verilog/pfm_pkg.sv
// Constants for the port 1 / port 2 function multiplexer.
// Assumes a byte-wide processor register bus and one system clock.
package pfm_pkg;
    // Direct register byte addresses
    localparam logic [7:0] PORT1_FUNCTION_SELECT_ADDR = 8'h2b;
    localparam logic [7:0] INDIRECT_INDEX_ADDR = 8'h2e;
    localparam logic [7:0] INDIRECT_DATA_ADDR = 8'h2f;
    // Indirect register indices
    localparam logic [7:0] PORT2_PULLUP_DISABLE_IDX = 8'h08;
    localparam logic [7:0] PORT2_FUNCTION_SELECT_IDX = 8'h13;
    // Reset values
    localparam logic [7:0] PORT1_FUNCTION_SELECT_RESET = 8'h3f;
    localparam logic [7:0] PORT2_FUNCTION_SELECT_RESET = 8'h10;
    localparam logic [7:0] PORT2_PULLUP_DISABLE_RESET = 8'h00;
    localparam logic [7:0] INDIRECT_INDEX_RESET = 8'h00;
    // Field layout
    localparam int P1_PIN_COUNT = 6;
    localparam int P2_PIN_COUNT = 6;
    localparam int P2_UPPER_ROUTE_BIT = 4;
    localparam int P2_SDA_PIN = 4;
    localparam int P2_SCL_PIN = 5;
    localparam logic [7:0] PORT1_SELECT_MASK = 8'h3f;
    localparam logic [7:0] PORT2_SELECT_MASK = 8'h10;
    localparam logic [7:0] PORT2_PULLUP_MASK = 8'h3f;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
    // Pad speed codes: fast while the upper pair carries the two-wire bus, normal otherwise
    localparam logic PAD_SPEED_FAST = 1'b1;
    localparam logic PAD_SPEED_NORMAL = 1'b0;
    localparam int PAD_FAST_SPEED_MHZ = 10;
endpackage

// file: verilog/pfm_input_sync.sv
// Three-stage synchroniser with agreement filter for pad inputs.
// Assumes inputs arrive from pads, asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pfm_input_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // Per-bit four flops, output follows once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                s1_q[i] <= 1'b1;
                s2_q[i] <= 1'b1;
                s3_q[i] <= 1'b1;
                sync_out[i] <= 1'b1;
            end else begin
                s1_q[i] <= async_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/test_pfm_port_mux.sv
// Self-checking bench for the port 1 / port 2 function multiplexer.
// Assumes the design files and pfm_pkg are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_pfm_port_mux;
    typedef struct {logic [7:0] sel; logic [5:0] pwm, gio, goe, eout, eoe;} pfm_row_type;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv;
    logic [5:0] pwm_out = 6'h2a, gio = 6'h15, gio_oe = 6'h00, p2_in = 6'h00;
    logic scl_low = 1'b1, sda_low = 1'b0;
    logic [5:0] p1_out, p1_oe, p2_out, p2_oe, pu_off, fdi;
    logic speed, scl_in, sda_in;
    int err_total = 0, n_compared = 0;
    pfm_row_type rows [4] = '{'{8'h3f, 6'h2a, 6'h15, 6'h00, 6'h2a, 6'h3f},
        '{8'h00, 6'h2a, 6'h15, 6'h0c, 6'h15, 6'h0c}, '{8'h15, 6'h3f, 6'h00, 6'h00, 6'h15, 6'h15},
        '{8'h2a, 6'h00, 6'h3f, 6'h01, 6'h15, 6'h2b}};

    pfm_port_mux dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pwm_out(pwm_out), .port1_general_io(gio),
        .port1_general_io_oe(gio_oe), .p1_pad_out(p1_out), .p1_pad_oe(p1_oe), .port2_input_lines(p2_in),
        .p2_pad_out(p2_out), .p2_pad_oe(p2_oe), .p2_pullup_off_bits(pu_off), .p2_upper_pad_speed(speed),
        .fast_digital_input(fdi), .i2c_scl_pull_low(scl_low), .i2c_sda_pull_low(sda_low),
        .i2c_scl_in(scl_in), .i2c_sda_in(sda_in));

    // Clock at 100 MHz
    always #5 clk = ~clk;

    // One write strobe, then an idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk) #1 reg_wr = 1'b0;
        @(posedge clk) #1;
    endtask

    // One read strobe, data taken the cycle after
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk) #1 reg_rd = 1'b0;
        @(posedge clk) #1 d = reg_rdata;
    endtask

    // Indirect access through index and data window
    task automatic iwr(input logic [7:0] i, input logic [7:0] d);
        wr(pfm_pkg::INDIRECT_INDEX_ADDR, i);
        wr(pfm_pkg::INDIRECT_DATA_ADDR, d);
    endtask

    task automatic ird(input logic [7:0] i, output logic [7:0] d);
        wr(pfm_pkg::INDIRECT_INDEX_ADDR, i);
        rd(pfm_pkg::INDIRECT_DATA_ADDR, d);
    endtask

    // Verdict and end of run
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #20000;
        err_total++;
        wrap_up;
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk) #1;
        `CHK("p1 oe after reset", 6'h3f, p1_oe)
        `CHK("p1 out after reset", 6'h2a, p1_out)
        `CHK("pullup off after reset", 6'h00, pu_off)
        rd(8'h2b, rv);
        `CHK("p1 select reset", 8'h3f, rv)
        ird(8'h08, rv);
        `CHK("pullup reg reset", 8'h00, rv)
        $display("test reset done");
        // Table of port 1 routings
        foreach (rows[i]) begin
            pwm_out = rows[i].pwm;
            gio = rows[i].gio;
            gio_oe = rows[i].goe;
            wr(8'h2b, rows[i].sel);
            `CHK("p1 pad out", rows[i].eout, p1_out)
            `CHK("p1 pad oe", rows[i].eoe, p1_oe)
            rd(8'h2b, rv);
            `CHK("p1 select readback", rows[i].sel, rv)
        end
        $display("test port1 table done");
        // Direct addresses do not reach the indirect registers
        wr(8'h08, 8'h3f);
        rd(8'h08, rv);
        `CHK("direct 08 read", 8'h00, rv)
        `CHK("pullup untouched", 6'h00, pu_off)
        iwr(8'h08, 8'h25);
        `CHK("pullup off bits", 6'h25, pu_off)
        ird(8'h08, rv);
        `CHK("pullup readback", 8'h25, rv)
        $display("test pullup done");
        // Port 2 pair to two-wire bus; reserved bits written set on purpose
        p2_in = 6'h0a;
        iwr(8'h13, 8'hef);
        `CHK("pad speed fast", 1'b1, speed)
        `CHK("p2 oe scl pull", 6'h20, p2_oe)
        `CHK("p2 pad out", 6'h00, p2_out)
        ird(8'h13, rv);
        `CHK("p2 select readback", 8'h00, rv)
        repeat (6) @(posedge clk);
        #1;
        `CHK("fast inputs on i2c", 6'h3a, fdi)
        `CHK("sda in", 1'b0, sda_in)
        `CHK("scl in low", 1'b0, scl_in)
        `CHK("pullup kept", 6'h25, pu_off)
        // Pair stays on the bus; levels and pulls differ per line to catch a crossed pair
        p2_in = 6'h2a;
        scl_low = 1'b0;
        sda_low = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK("scl in on i2c", 1'b1, scl_in)
        `CHK("sda in on i2c", 1'b0, sda_in)
        `CHK("p2 oe sda pull", 6'h10, p2_oe)
        `CHK("fast inputs held", 6'h3a, fdi)
        `CHK("pad speed still fast", 1'b1, speed)
        // Back to fast digital inputs
        iwr(8'h13, 8'h10);
        #20;
        `CHK("pad speed normal", 1'b0, speed)
        `CHK("p2 oe released", 6'h00, p2_oe)
        `CHK("fast inputs", 6'h2a, fdi)
        `CHK("scl in idle", 1'b1, scl_in)
        rd(8'h13, rv);
        `CHK("direct 13 read", 8'h00, rv)
        $display("test port2 done");
        // Mid-run reset with the pair on the bus and every register away from reset
        iwr(8'h13, 8'h00);
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk) #1;
        `CHK("p1 oe after second reset", 6'h3f, p1_oe)
        `CHK("p1 out after second reset", 6'h00, p1_out)
        `CHK("pullup off after second reset", 6'h00, pu_off)
        `CHK("pad speed after second reset", 1'b0, speed)
        ird(8'h13, rv);
        `CHK("p2 select after second reset", 8'h10, rv)
        rd(8'h2b, rv);
        `CHK("p1 select after second reset", 8'h3f, rv)
        $display("test mid-run reset done");
        wrap_up;
    end
endmodule
`undef CHK
`default_nettype wire
